// ### design/rsv_consts.vh
`ifndef RSV_CONSTS_VH
`define RSV_CONSTS_VH
// register index (printed offset not a multiple of four: byte address is 4x)
`define RSV_IDX_STARTUP 8'h73
`define RSV_IDX_REGCTRL 8'h10
`define RSV_IDX_STATUS 8'h1B
`define RSV_IDX_SOURCE 8'h03
`define RSV_IDX_EVENTS 8'h61
`define RSV_IDX_EVEN 8'h1C
`define RSV_IDX_WDCTRL 8'h02
`define RSV_IDX_CMD 8'h01
// start-up register fields
`define RSV_RLC_HI 5
`define RSV_RLC_LO 4
`define RSV_SUC_BIT 3
`define RSV_STARTUP_RST 8'h00
`define RSV_STARTUP_MASK 8'h38
// mode codes
`define RSV_M_NORMAL 3'h0
`define RSV_M_STANDBY 3'h1
`define RSV_M_SLEEP 3'h2
`define RSV_M_RESET 3'h3
`define RSV_M_OTP 3'h4
`define RSV_M_OFF 3'h5
// reset source codes
`define RSV_SRC_NONE 4'h0
`define RSV_SRC_OFF_EXIT 4'h1
`define RSV_SRC_CAN_WAKE 4'h2
`define RSV_SRC_DIAG_WAKE 4'h3
`define RSV_SRC_LOCAL_WAKE 4'h4
`define RSV_SRC_WD_EARLY 4'h5
`define RSV_SRC_WD_OVF 4'h6
`define RSV_SRC_ILL_SLEEP 4'h7
`define RSV_SRC_EXT_PIN 4'h8
`define RSV_SRC_OTP_EXIT 4'h9
`define RSV_SRC_UV 4'hA
`define RSV_SRC_NV_PROG 4'hB
`define RSV_SRC_FRAME_ERR 4'hC
`define RSV_SRC_WDCHG 4'hD
// pulse widths in microseconds, least figure of each printed range
`define RSV_W00_US 20000
`define RSV_W01_US 10000
`define RSV_W10_US 3600
`define RSV_W11_US 1000
`define RSV_CLK_MHZ 25
`define RSV_CMD_SLEEP 8'h01
`endif

// ### design/rsv_reset_supervisor.v
// What this block does
// - any reset enters reset mode, pulses pin
// - external pin pull-down detected as reset
// - undervoltage-linked resets use selected cold width
// - watchdog, pin and illegal-sleep resets use shortest width
// - width field selects four cold pulse lengths
// - start-up bit loads aux config 00/11
// - undervoltage resets except sleep, overtemp or off
// - reset after nv programming and off exit
// - watchdog faults and pending-fail overflow reset
// - watchdog reconfigure in normal resets
// - every sleep wake-up passes reset mode
// - overtemp exit and illegal sleep reset
// - overtemp enters otp mode, supplies off
// - cooled overtemp goes standby via reset
// - warning threshold sets status and event
// - low battery enters off mode
// - power-on start-up delay, then reset, event
// - threshold select, fixed in low-voltage variant
// - threshold loaded from nv default
// - enabled 90 percent dip captures event
// - 90 percent status readable
// - reset cause readable as source code
//
// Decided for this implementation: the Avalon-MM register port.
`include "rsv_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module rsv_reset_supervisor #(
  parameter W00_CYC = `RSV_W00_US * `RSV_CLK_MHZ,
  parameter W01_CYC = `RSV_W01_US * `RSV_CLK_MHZ,
  parameter W10_CYC = `RSV_W10_US * `RSV_CLK_MHZ,
  parameter W11_CYC = `RSV_W11_US * `RSV_CLK_MHZ,
  parameter STARTUP_CYC = 25000,
  parameter LOW_V_VARIANT = 0,
  parameter CW = 20
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire reset_pin_in,
  output wire reset_out_n_pin_o,
  output wire reset_out_n_pin_oe,
  input wire [1:0] main_supply_thresh_default,
  input wire nv_startup_suc,
  input wire [1:0] nv_startup_rlc,
  input wire main_supply_below_sel,
  input wire main_supply_below_90,
  input wire bat_below_poff,
  input wire bat_above_pon,
  input wire temp_above_act,
  input wire temp_below_rel,
  input wire temp_above_warn,
  input wire nv_prog_done,
  input wire wd_overflow_window,
  input wire wd_early_window,
  input wire wd_overflow_timeout,
  input wire wake_local,
  input wire wake_can,
  input wire wake_diag,
  input wire wake_frame_err,
  input wire sleep_cmd_illegal,
  input wire [2:0] mode_req,
  input wire mode_req_valid,
  output reg [2:0] mode,
  output wire main_supply_on,
  output wire aux_supply_on,
  output wire can_on,
  output wire pnp_on,
  output reg [1:0] main_supply_reset_thresh
);
  reg [7:0] startup;
  reg [1:0] aux_supply_cfg;
  reg main_supply_uv_event_en;
  reg wdog_fail_pending;
  reg overtemp_warn_event;
  reg poweron_event;
  reg main_supply_undervolt_event;
  reg [3:0] reset_source_code;
  reg cold;
  reg [CW-1:0] cnt;
  reg [CW-1:0] su_cnt;
  reg ack;
  reg pin_q;
  reg warn_q;
  reg uv_q;
  reg loaded;
  reg [3:0] src;
  wire [7:0] idx = avs_address[9:2];
  wire req = avs_read | avs_write;
  // write lands on the edge where waitrequest is seen low
  wire wr = avs_write & ack & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  // one wait cycle so every answer is registered
  assign avs_waitrequest = req & ~ack;
  wire in_sleep = (mode == `RSV_M_SLEEP);
  wire in_otp = (mode == `RSV_M_OTP);
  wire in_off = (mode == `RSV_M_OFF);
  wire pin_low_ext = ~reset_pin_in & (mode != `RSV_M_RESET) & ~in_otp & ~in_off;
  wire wd_change = wr & (idx == `RSV_IDX_WDCTRL) & (mode == `RSV_M_NORMAL);
  wire uv_reset = main_supply_below_sel & ~in_sleep & ~in_otp & ~in_off;
  wire otp_exit = in_otp & temp_below_rel;
  wire sleep_wake = in_sleep & (wake_local | wake_can | wake_diag | wake_frame_err);
  wire wd_ovf_fail = wd_overflow_timeout & wdog_fail_pending;
  // priority picks one code when several arrive together
  always @* begin
    src = `RSV_SRC_NONE;
    if (wd_change)
      src = `RSV_SRC_WDCHG;
    if (sleep_cmd_illegal & ~in_off & ~in_otp)
      src = `RSV_SRC_ILL_SLEEP;
    if (pin_low_ext)
      src = `RSV_SRC_EXT_PIN;
    if (~in_off & ~in_otp & ~in_sleep & (wd_overflow_window | wd_ovf_fail))
      src = `RSV_SRC_WD_OVF;
    if (~in_off & ~in_otp & ~in_sleep & wd_early_window)
      src = `RSV_SRC_WD_EARLY;
    if (sleep_wake & wake_frame_err)
      src = `RSV_SRC_FRAME_ERR;
    else if (sleep_wake & wake_diag)
      src = `RSV_SRC_DIAG_WAKE;
    else if (sleep_wake & wake_can)
      src = `RSV_SRC_CAN_WAKE;
    else if (sleep_wake)
      src = `RSV_SRC_LOCAL_WAKE;
    if (uv_reset)
      src = `RSV_SRC_UV;
    if (otp_exit)
      src = `RSV_SRC_OTP_EXIT;
  end
  wire src_cold = uv_reset | otp_exit | sleep_wake | main_supply_below_sel;
  wire [CW-1:0] cold_len =
    (startup[`RSV_RLC_HI:`RSV_RLC_LO] == 2'b00) ? W00_CYC[CW-1:0] :
    (startup[`RSV_RLC_HI:`RSV_RLC_LO] == 2'b01) ? W01_CYC[CW-1:0] :
    (startup[`RSV_RLC_HI:`RSV_RLC_LO] == 2'b10) ? W10_CYC[CW-1:0] :
    W11_CYC[CW-1:0];
  wire [CW-1:0] next_len = (cold | src_cold) ? cold_len : W11_CYC[CW-1:0];
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `RSV_M_OFF;
      cnt <= {CW{1'b0}};
      su_cnt <= {CW{1'b0}};
      cold <= 1'b1;
      reset_source_code <= `RSV_SRC_NONE;
      poweron_event <= 1'b0;
    end else begin
      // clear first so a same-cycle power-on set wins
      if (wr & (idx == `RSV_IDX_EVENTS) & wd[0])
        poweron_event <= 1'b0;
      if (bat_below_poff) begin
      mode <= `RSV_M_OFF;
      su_cnt <= {CW{1'b0}};
      cold <= 1'b1;
    end else if (in_off) begin
      if (!bat_above_pon)
        su_cnt <= {CW{1'b0}};
      else if (su_cnt < STARTUP_CYC[CW-1:0] - 1'b1)
        su_cnt <= su_cnt + 1'b1;
      else begin
        mode <= `RSV_M_RESET;
        cnt <= cold_len;
        poweron_event <= 1'b1;
        reset_source_code <= `RSV_SRC_OFF_EXIT;
      end
    end else if (nv_prog_done) begin
      mode <= `RSV_M_OFF;
      su_cnt <= {CW{1'b0}};
      cold <= 1'b1;
      reset_source_code <= `RSV_SRC_NV_PROG;
    end else if (temp_above_act & ~in_sleep & ~in_otp) begin
      mode <= `RSV_M_OTP;
    end else if (src != `RSV_SRC_NONE) begin
      mode <= `RSV_M_RESET;
      cnt <= next_len;
      cold <= cold | src_cold;
      reset_source_code <= src;
    end else if (mode == `RSV_M_RESET) begin
      if (main_supply_below_sel)
        cold <= 1'b1;
      if (cnt > 1)
        cnt <= cnt - 1'b1;
      else begin
        mode <= `RSV_M_STANDBY;
        cold <= 1'b0;
      end
    end else if (mode_req_valid & ~in_otp) begin
      case (mode_req)
        `RSV_M_NORMAL: mode <= `RSV_M_NORMAL;
        `RSV_M_STANDBY: mode <= `RSV_M_STANDBY;
        `RSV_M_SLEEP: mode <= `RSV_M_SLEEP;
        default: mode <= mode;
      endcase
    end
    end
  end
  // reset/otp/off modes drive low; ext pin pull enters reset mode, pin low held there
  assign reset_out_n_pin_o = 1'b0;
  assign reset_out_n_pin_oe = (mode == `RSV_M_RESET) | in_otp | in_off;
  assign main_supply_on = ~in_otp & ~in_sleep & ~in_off;
  assign can_on = ~in_otp & ~in_off & ~in_sleep;
  assign pnp_on = main_supply_on;
  assign aux_supply_on = ~in_otp & ~in_off & (
    (aux_supply_cfg == 2'b11) |
    ((aux_supply_cfg == 2'b10) & ~in_sleep) |
    ((aux_supply_cfg == 2'b01) & (mode == `RSV_M_NORMAL)));
  // register file and event flags; hardware set wins over clear
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startup <= `RSV_STARTUP_RST;
      aux_supply_cfg <= 2'b00;
      main_supply_reset_thresh <= 2'b00;
      main_supply_uv_event_en <= 1'b0;
      wdog_fail_pending <= 1'b0;
      overtemp_warn_event <= 1'b0;
      main_supply_undervolt_event <= 1'b0;
      loaded <= 1'b0;
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      warn_q <= 1'b0;
      uv_q <= 1'b0;
    end else begin
      ack <= req & ~ack;
      warn_q <= temp_above_warn & ~in_sleep & ~in_off;
      uv_q <= main_supply_below_90;
      if (!loaded) begin
        // nv image caught after release, not under reset
        loaded <= 1'b1;
        startup <= {2'b00, nv_startup_rlc, nv_startup_suc, 3'b000};
        aux_supply_cfg <= nv_startup_suc ? 2'b11 : 2'b00;
        main_supply_reset_thresh <= LOW_V_VARIANT ? 2'b00 : main_supply_thresh_default;
      end else begin
        if (wr & (idx == `RSV_IDX_STARTUP))
          startup <= wd & `RSV_STARTUP_MASK;
        if (wr & (idx == `RSV_IDX_REGCTRL)) begin
          aux_supply_cfg <= wd[3:2];
          // low-voltage variant keeps 90 percent
          main_supply_reset_thresh <= LOW_V_VARIANT ? 2'b00 : wd[1:0];
        end
        if (wr & (idx == `RSV_IDX_EVEN))
          main_supply_uv_event_en <= wd[0];
      end
      if (wd_overflow_timeout)
        wdog_fail_pending <= 1'b1;
      else if (wr & (idx == `RSV_IDX_EVENTS) & wd[3])
        wdog_fail_pending <= 1'b0;
      if (temp_above_warn & ~in_sleep & ~in_off & ~warn_q)
        overtemp_warn_event <= 1'b1;
      else if (wr & (idx == `RSV_IDX_EVENTS) & wd[1])
        overtemp_warn_event <= 1'b0;
      if (main_supply_uv_event_en & main_supply_below_90 & ~uv_q)
        main_supply_undervolt_event <= 1'b1;
      else if (wr & (idx == `RSV_IDX_EVENTS) & wd[2])
        main_supply_undervolt_event <= 1'b0;
      if (avs_read & ~ack) begin
        case (idx)
          `RSV_IDX_STARTUP: avs_readdata <= {24'h000000, startup};
          `RSV_IDX_REGCTRL: avs_readdata <= {28'h0000000, aux_supply_cfg,
            main_supply_reset_thresh};
          `RSV_IDX_STATUS: avs_readdata <= {29'h00000000, in_otp, temp_above_warn,
            main_supply_below_90};
          `RSV_IDX_SOURCE: avs_readdata <= {25'h0000000, mode, reset_source_code};
          `RSV_IDX_EVENTS: avs_readdata <= {28'h0000000, wdog_fail_pending,
            main_supply_undervolt_event, overtemp_warn_event, poweron_event};
          `RSV_IDX_EVEN: avs_readdata <= {31'h00000000, main_supply_uv_event_en};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/rsv_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rsv_assertions #(
  parameter W11_CYC = 10
) (
  input wire ref_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_waitrequest,
  input wire reset_pin_in,
  input wire reset_out_n_pin_oe,
  input wire temp_above_act,
  input wire temp_below_rel,
  input wire bat_below_poff,
  input wire wd_early_window,
  input wire [2:0] mode,
  input wire main_supply_on,
  input wire aux_supply_on,
  input wire can_on,
  input wire pnp_on
);
  // cycles spent in reset mode so far
  reg [15:0] run;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run <= 16'h0000;
    else run <= (mode == 3'h3) ? run + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_PIN_DRIVE: assert property (reset_out_n_pin_oe == (mode >= 3'h3))
    else $error("pin drive does not follow mode");
  AST_OTP_OFF: assert property (mode == 3'h4 |-> !(main_supply_on | aux_supply_on | can_on | pnp_on))
    else $error("supply on in overtemp");
  AST_OTP_IN: assert property (temp_above_act && mode <= 3'h1 |-> ##[1:4] mode == 3'h4)
    else $error("no overtemp entry");
  AST_OTP_EXIT: assert property (mode == 3'h4 && temp_below_rel |-> ##[1:4] mode == 3'h3)
    else $error("no reset after overtemp");
  AST_PIN_RESET: assert property (!reset_pin_in && mode <= 3'h1 |-> ##[1:4] mode == 3'h3)
    else $error("pin pull-down missed");
  AST_POWER_OFF: assert property (bat_below_poff && mode != 3'h5 |-> ##[1:4] mode == 3'h5)
    else $error("no off mode");
  AST_WD_EARLY: assert property (wd_early_window && mode == 3'h0 |-> ##[1:4] mode == 3'h3)
    else $error("early trigger missed");
  AST_WAIT_ONE: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read answer late");
  AST_WARM_MIN: assert property (mode == 3'h1 && run != 0 |-> run >= W11_CYC - 1)
    else $error("reset pulse too short");
endmodule
bind rsv_reset_supervisor rsv_assertions #(.W11_CYC(W11_CYC)) u_rsv_assertions (.*);
`default_nettype wire

// ### tb/rsv_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rsv_host_model #(
  parameter HOLD_CYC = 4
) (
  input wire ref_clk,
  input wire dev_oe,
  input wire pull_req,
  output wire pin_level
);
  int left = 0;
  // held past the minimum input width so the pull is never missed
  always @(posedge ref_clk) begin
    if (pull_req) left <= HOLD_CYC;
    else if (left > 0) left <= left - 1;
  end
  // open drain with pull-up: high unless a party pulls
  assign pin_level = !(dev_oe || left > 0);
endmodule
`default_nettype wire

// ### tb/tb_rsv_reset_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsv_consts.vh"
module tb_rsv_reset_supervisor;
  localparam int W01 = 30, W10 = 20, W11 = 10;
  logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, reset_pin_in, pull = 0;
  logic [9:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] main_supply_thresh_default = 2'h1, nv_startup_rlc = 2'h2, main_supply_reset_thresh;
  logic nv_startup_suc = 1, main_supply_below_sel = 0, main_supply_below_90 = 0;
  logic bat_below_poff = 0, bat_above_pon = 1, temp_above_act = 0, temp_below_rel = 0;
  logic temp_above_warn = 0, nv_prog_done = 0, wd_overflow_window = 0, wd_early_window = 0;
  logic wd_overflow_timeout = 0, wake_local = 0, wake_can = 0, wake_diag = 0;
  logic wake_frame_err = 0, sleep_cmd_illegal = 0, mode_req_valid = 0;
  logic [2:0] mode_req = 0, mode;
  logic avs_waitrequest, reset_out_n_pin_o, reset_out_n_pin_oe;
  logic main_supply_on, aux_supply_on, can_on, pnp_on;
  int fail_count = 0, n_checks = 0, run_len = 0, last_len = 0;
  int ks[7] = '{5, 6, 7, 2, 3, 4, 12};
  always #20 ref_clk = ~ref_clk;
  rsv_reset_supervisor #(.W00_CYC(40), .W01_CYC(W01), .W10_CYC(W10), .W11_CYC(W11),
    .STARTUP_CYC(5)) u_rsv_reset_supervisor (.*);
  rsv_host_model #(.HOLD_CYC(4)) u_rsv_host_model (.ref_clk(ref_clk),
    .dev_oe(reset_out_n_pin_oe), .pull_req(pull), .pin_level(reset_pin_in));
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge ref_clk);
  endtask
  task go(input logic [2:0] m);
    mode_req <= m;
    mode_req_valid <= 1;
    @(posedge ref_clk);
    mode_req_valid <= 0;
    @(posedge ref_clk iff mode === m);
  endtask
  task fire(input int k);
    case (k)
      2: wake_can <= 1;
      3: wake_diag <= 1;
      4: wake_local <= 1;
      5: wd_early_window <= 1;
      6: wd_overflow_window <= 1;
      7: sleep_cmd_illegal <= 1;
      default: wake_frame_err <= 1;
    endcase
    @(posedge ref_clk);
    {wake_can, wake_diag, wake_local, wd_early_window} <= 4'h0;
    {wd_overflow_window, sleep_cmd_illegal, wake_frame_err} <= 3'h0;
  endtask
  // a pulse is timed from its first reset cycle up to standby
  always @(posedge ref_clk) begin
    if (mode === 3'h3) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) last_len <= run_len;
      run_len <= 0;
    end
  end
  task rst_seen(input int w, input logic [3:0] code);
    @(posedge ref_clk iff mode === 3'h3);
    @(posedge ref_clk iff mode === 3'h1);
    @(posedge ref_clk);
    chk(last_len, w);
    bus(0, `RSV_IDX_SOURCE, 0);
    chk(rd[3:0], code);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    rst_seen(W10, `RSV_SRC_OFF_EXIT);
    chk(main_supply_reset_thresh, 2'h1);
    bus(0, `RSV_IDX_STARTUP, 0);
    chk(rd, 32'h28);
    bus(0, `RSV_IDX_REGCTRL, 0);
    chk(rd[3:0], 4'hD);
    bus(0, `RSV_IDX_EVENTS, 0);
    chk(rd[0], 1);
    bus(1, `RSV_IDX_STARTUP, 8'h1F);
    bus(0, `RSV_IDX_STARTUP, 0);
    chk(rd, 32'h18);
    bus(0, 8'hFF, 0);
    chk(rd, 0);
    for (int i = 0; i < 7; i++) begin
      go(i < 3 ? 3'h0 : 3'h2);
      fire(ks[i]);
      rst_seen(i < 3 ? W11 : W01, ks[i][3:0]);
    end
    go(0);
    bus(1, `RSV_IDX_WDCTRL, 8'h01);
    rst_seen(W11, `RSV_SRC_WDCHG);
    pull <= 1;
    @(posedge ref_clk);
    pull <= 0;
    rst_seen(W11, `RSV_SRC_EXT_PIN);
    main_supply_below_sel <= 1;
    @(posedge ref_clk);
    main_supply_below_sel <= 0;
    rst_seen(W01, `RSV_SRC_UV);
    temp_above_act <= 1;
    @(posedge ref_clk iff mode === 3'h4);
    temp_above_act <= 0;
    temp_below_rel <= 1;
    rst_seen(W01, `RSV_SRC_OTP_EXIT);
    temp_below_rel <= 0;
    temp_above_warn <= 1;
    bus(1, `RSV_IDX_EVEN, 8'h01);
    main_supply_below_90 <= 1;
    repeat (3) @(posedge ref_clk);
    bus(0, `RSV_IDX_STATUS, 0);
    chk(rd[1:0], 2'h3);
    bus(0, `RSV_IDX_EVENTS, 0);
    chk(rd[2:1], 2'h3);
    bat_below_poff <= 1;
    repeat (5) @(posedge ref_clk);
    chk(mode, 3'h5);
    complete_run;
  end
endmodule
`default_nettype wire
